/* power_ctrl_pkg.sv */
// Shared constants of the control-processor power logic register bank
package power_ctrl_pkg;
	// Register byte offsets inside the 64KB footprint
	localparam logic [15:0] OFS_WAKEUP_STATE = 16'h0018;
	localparam logic [15:0] OFS_FORCE_STATE = 16'h0a00;
	localparam logic [15:0] OFS_FORCE_SET = 16'h0a04;
	localparam logic [15:0] OFS_FORCE_CLEAR = 16'h0a08;
	localparam logic [15:0] OFS_PLL_LO = 16'h0a10;
	localparam logic [15:0] OFS_PLL_HI = 16'h0a14;
	localparam logic [15:0] OFS_CONFIG = 16'h0fc0;
	localparam logic [15:0] OFS_BLOCK_IDENT = 16'h0fd0;

	// Clock force fields, shared by state, set and clear
	localparam int FORCE_WIDTH = 2;
	localparam int BIT_PROC_CLOCK = 1;
	localparam int BIT_REF_CLOCK = 0;
	localparam logic [1:0] FORCE_RESET = 2'h0;

	// Lock status field positions in the low lock register
	localparam int BIT_NPU_PLL = 7;
	localparam int BIT_DISPLAY_PLL = 6;
	localparam int BIT_SYSTEM_PLL = 5;
	localparam int BIT_VIDEO_PLL = 4;
	localparam int BIT_GPU_PLL = 3;
	localparam int BIT_REF_STATE = 0;
	localparam int CLUSTER_PLLS = 8;
	localparam int LOCK_INPUTS = 6 + 2 * CLUSTER_PLLS;
	localparam logic [31:0] LOCK_RESET = 32'h0000_0000;

	// Configuration word fields
	localparam logic [3:0] POLICY_UNIT_COUNT = 4'h1;
	localparam int CONFIG_ID_LSB = 16;

	// Footprint, in 4KB blocks as a power of two
	localparam int FOOTPRINT_KB = 64;
	localparam int BLOCK_KB = 4;
	localparam logic [3:0] BLOCK_COUNT_LOG2 = 4'($clog2(FOOTPRINT_KB / BLOCK_KB));
	localparam int BLOCK_COUNT_LSB = 4;

	// Wakeup sleep flag after reset, enabled reads as zero
	localparam logic WAKEUP_FLAG_RESET = 1'h0;

	// Synchroniser depth for lock inputs
	localparam int SYNC_STAGES = 2;
endpackage

/* clock_force_if.sv */
// Carrier between register decode and the clock force state
interface clock_force_if;
	logic [power_ctrl_pkg::FORCE_WIDTH-1:0] set_bits;
	logic [power_ctrl_pkg::FORCE_WIDTH-1:0] clear_bits;
	logic [power_ctrl_pkg::FORCE_WIDTH-1:0] state;
	logic [power_ctrl_pkg::FORCE_WIDTH-1:0] next_state;

	modport ctrl (input set_bits, input clear_bits, output state, output next_state);
	modport regs (output set_bits, output clear_bits, input state, input next_state);
endinterface

/* clock_force_ctrl.sv */
// Clock force state with one-shot set and clear strobes
module clock_force_ctrl (
	input wire logic clk,
	input wire logic rstn,
	clock_force_if.ctrl force_bus
);

	// Set is applied after clear so a collision keeps the clock forced on
	always_comb
	begin
		force_bus.next_state = force_bus.state;
		force_bus.next_state = force_bus.next_state & ~force_bus.clear_bits; // [RQ5]
		force_bus.next_state = force_bus.next_state | force_bus.set_bits; // [RQ4]
	end

	// Gating enabled for both clocks until software forces them
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			force_bus.state <= power_ctrl_pkg::FORCE_RESET; // [RQ17]
		else
			force_bus.state <= force_bus.next_state;
	end

	a_set_wins: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
		(force_bus.set_bits != 2'h0) |=> ((force_bus.state & $past(force_bus.set_bits)) == $past(force_bus.set_bits)))
		else $error("forced bit not set after set strobe");
	a_idle_hold: assert property (@(posedge clk) disable iff (!rstn) // [RQ4] [RQ5]
		(force_bus.set_bits == 2'h0 && force_bus.clear_bits == 2'h0) |=> $stable(force_bus.state))
		else $error("force state moved without a strobe");

endmodule

/* power_ctrl_clock_status_regs.sv */
// AHB-Lite register bank for clock force, lock status and identification
//
// Operation
// [RQ1] Wakeup status bit0: 0 enabled, 1 disabled
// [RQ2] Force status bit 1 means gating disabled
// [RQ3] Bit1 processor clock, bit0 reference clock
// [RQ4] Set register ones force clock, zeros ignored
// [RQ5] Clear register ones restore gating, zeros ignored
// [RQ6] Low lock register maps five PLLs, reference
// [RQ7] High lock register: cluster1 high, cluster0 low
// [RQ8] Lock registers read-only, live, zero at reset
// [RQ9] Config bits 3:0 give one policy unit
// [RQ10] Config bits 31:16 hold logic identifier
// [RQ11] Identification bits 7:4 give 64KB footprint
// [RQ12] Identification bits 3:0 maker continuation code
// [RQ13] Identification bits 31:8 read zero
// [RQ14] Wakeup status follows the sleep request
// [RQ15] Reserved offsets read zero, ignore writes
// [RQ16] Write-only reads zero, read-only writes ignored
// [RQ17] Force bits reset to zero
//
// Design decision made here: the AHB-Lite slave port.
module power_ctrl_clock_status_regs #(
	// Arbitrary neutral value, stands for the logic identifier
	parameter logic [15:0] LOGIC_ID = 16'h0a5a,
	// Arbitrary neutral value, stands for the continuation count
	parameter logic [3:0] MAKER_CONTINUATION = 4'h0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic wakeup_sleep_request,
	input wire logic npu_pll_locked,
	input wire logic display_pll_locked,
	input wire logic system_pll_locked,
	input wire logic video_pll_locked,
	input wire logic gpu_pll_locked,
	input wire logic ref_clock_state,
	input wire logic [7:0] cluster1_pll_locked,
	input wire logic [7:0] cluster0_pll_locked,
	output logic proc_clock_force_bit,
	output logic ref_clock_force_bit,
	output logic wakeup_sleep_enabled_flag
);

	localparam int LI = power_ctrl_pkg::LOCK_INPUTS;
	localparam int CP = power_ctrl_pkg::CLUSTER_PLLS;

	// Address hit on one word of the footprint
	function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
		hit = (addr[15:2] == ofs[15:2]);
	endfunction

	clock_force_if force_bus ();

	clock_force_ctrl u_force (
		.clk(clk),
		.rstn(rstn),
		.force_bus(force_bus)
	);

	// Address phase capture
	logic take;
	logic wr_pending;
	logic [15:0] wr_addr;
	logic [LI-1:0] lock_raw;
	logic [LI-1:0] lock_meta;
	logic [LI-1:0] lock_sync;
	logic [31:0] pll_lo;
	logic [31:0] pll_hi;
	logic [31:0] next_rdata;
	logic [1:0] fwd_force;

	assign take = hsel && htrans[1] && hready;

	// Write address held for the data phase; hsize other than word still writes the word
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_pending <= 1'b0;
			wr_addr <= 16'h0000;
		end
		else if (hready)
		begin
			wr_pending <= take && hwrite;
			wr_addr <= haddr[15:0];
		end
	end

	// Strobes to the force state, only in the data phase of a write
	always_comb
	begin
		force_bus.set_bits = 2'h0;
		force_bus.clear_bits = 2'h0;
		if (wr_pending && hit(wr_addr, power_ctrl_pkg::OFS_FORCE_SET))
			force_bus.set_bits = hwdata[1:0]; // [RQ4] [RQ3]
		if (wr_pending && hit(wr_addr, power_ctrl_pkg::OFS_FORCE_CLEAR))
			force_bus.clear_bits = hwdata[1:0]; // [RQ5] [RQ3]
	end

	// Every other write address, read-only or reserved, has no target at all
	// Lock inputs come from other clock domains
	assign lock_raw = {cluster1_pll_locked, cluster0_pll_locked, npu_pll_locked, display_pll_locked,
		system_pll_locked, video_pll_locked, gpu_pll_locked, ref_clock_state};

	// Two-flop synchroniser per lock line
	generate
		for (genvar i = 0; i < LI; i++)
		begin : g_sync
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
				begin
					lock_meta[i] <= 1'b0;
					lock_sync[i] <= 1'b0;
				end
				else
				begin
					lock_meta[i] <= lock_raw[i];
					lock_sync[i] <= lock_meta[i]; // [RQ8]
				end
			end
		end
	endgenerate

	// Lock register images from synchronised lines
	always_comb
	begin
		pll_lo = power_ctrl_pkg::LOCK_RESET;
		pll_lo[power_ctrl_pkg::BIT_NPU_PLL] = lock_sync[5]; // [RQ6]
		pll_lo[power_ctrl_pkg::BIT_DISPLAY_PLL] = lock_sync[4];
		pll_lo[power_ctrl_pkg::BIT_SYSTEM_PLL] = lock_sync[3];
		pll_lo[power_ctrl_pkg::BIT_VIDEO_PLL] = lock_sync[2];
		pll_lo[power_ctrl_pkg::BIT_GPU_PLL] = lock_sync[1];
		pll_lo[power_ctrl_pkg::BIT_REF_STATE] = lock_sync[0];
		pll_hi = power_ctrl_pkg::LOCK_RESET;
		pll_hi[2*CP-1:0] = lock_sync[LI-1:6]; // [RQ7]
	end

	// Status read of the force bits sees a write finishing this same cycle
	assign fwd_force = force_bus.next_state;

	// Read mux for the address phase; unmapped words answer zero
	always_comb
	begin
		next_rdata = 32'h0000_0000; // [RQ15] [RQ16]
		if (hit(haddr[15:0], power_ctrl_pkg::OFS_WAKEUP_STATE))
			next_rdata[0] = wakeup_sleep_enabled_flag; // [RQ1]
		else if (hit(haddr[15:0], power_ctrl_pkg::OFS_FORCE_STATE))
			next_rdata[1:0] = fwd_force; // [RQ2] [RQ3]
		else if (hit(haddr[15:0], power_ctrl_pkg::OFS_PLL_LO))
			next_rdata = pll_lo; // [RQ8]
		else if (hit(haddr[15:0], power_ctrl_pkg::OFS_PLL_HI))
			next_rdata = pll_hi; // [RQ8]
		else if (hit(haddr[15:0], power_ctrl_pkg::OFS_CONFIG))
		begin
			next_rdata[31:power_ctrl_pkg::CONFIG_ID_LSB] = LOGIC_ID; // [RQ10]
			next_rdata[3:0] = power_ctrl_pkg::POLICY_UNIT_COUNT; // [RQ9]
		end
		else if (hit(haddr[15:0], power_ctrl_pkg::OFS_BLOCK_IDENT))
		begin
			next_rdata[7:power_ctrl_pkg::BLOCK_COUNT_LSB] = power_ctrl_pkg::BLOCK_COUNT_LOG2; // [RQ11] [RQ13]
			next_rdata[3:0] = MAKER_CONTINUATION; // [RQ12]
		end
	end

	// Read data registered at the address phase, so reads have no wait state
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite)
			hrdata <= next_rdata;
	end

	// Slave never stalls and never errors
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Wakeup status follows the sleep request input, registered one cycle later
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			wakeup_sleep_enabled_flag <= power_ctrl_pkg::WAKEUP_FLAG_RESET;
		else
			wakeup_sleep_enabled_flag <= wakeup_sleep_request; // [RQ14] [RQ1]
	end

	// Force outputs to the clock gating cells
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			proc_clock_force_bit <= 1'b0;
			ref_clock_force_bit <= 1'b0;
		end
		else
		begin
			proc_clock_force_bit <= fwd_force[power_ctrl_pkg::BIT_PROC_CLOCK]; // [RQ2] [RQ3]
			ref_clock_force_bit <= fwd_force[power_ctrl_pkg::BIT_REF_CLOCK]; // [RQ2] [RQ3]
		end
	end

	// Helper state for the read checks
	logic rd_seen;
	logic [15:0] rd_addr;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_seen <= 1'b0;
			rd_addr <= 16'h0000;
		end
		else
		begin
			rd_seen <= take && !hwrite;
			rd_addr <= haddr[15:0];
		end
	end

	// Write data phase to set or clear with a given pattern
	sequence set_write(logic [1:0] pat);
		wr_pending && hit(wr_addr, power_ctrl_pkg::OFS_FORCE_SET) && hwdata[1:0] == pat;
	endsequence
	sequence clear_write(logic [1:0] pat);
		wr_pending && hit(wr_addr, power_ctrl_pkg::OFS_FORCE_CLEAR) && hwdata[1:0] == pat;
	endsequence

	a_set_proc_on: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
		set_write(2'h2) ##1 1'b1 |-> proc_clock_force_bit && force_bus.state[1])
		else $error("processor clock not forced after set");
	a_clear_ref_off: assert property (@(posedge clk) disable iff (!rstn) // [RQ5]
		clear_write(2'h1) |=> !ref_clock_force_bit && !force_bus.state[0])
		else $error("reference clock still forced after clear");
	a_clear_zero_keep: assert property (@(posedge clk) disable iff (!rstn) // [RQ5]
		clear_write(2'h0) |=> force_bus.state == $past(force_bus.state))
		else $error("zero clear changed force state");
	a_force_out_map: assert property (@(posedge clk) disable iff (!rstn) // [RQ2]
		{proc_clock_force_bit, ref_clock_force_bit} == force_bus.state)
		else $error("force outputs differ from status");
	a_force_reset: assert property (@(posedge clk) disable iff (!rstn) // [RQ17]
		!$past(rstn) |-> force_bus.state == 2'h0 && !proc_clock_force_bit)
		else $error("force bits not zero after reset");
	a_wo_reads_zero: assert property (@(posedge clk) disable iff (!rstn) // [RQ16]
		rd_seen && (hit(rd_addr, power_ctrl_pkg::OFS_FORCE_SET) || hit(rd_addr, power_ctrl_pkg::OFS_FORCE_CLEAR))
		|-> hrdata == 32'h0000_0000)
		else $error("write-only register read nonzero");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn) // [RQ15]
		rd_seen && rd_addr[15:12] != 4'h0 |-> hrdata == 32'h0000_0000)
		else $error("reserved block read nonzero");
	a_config_word: assert property (@(posedge clk) disable iff (!rstn) // [RQ9] [RQ10]
		rd_seen && hit(rd_addr, power_ctrl_pkg::OFS_CONFIG) |-> hrdata == {LOGIC_ID, 12'h000, 4'h1})
		else $error("configuration word wrong");
	a_ident_word: assert property (@(posedge clk) disable iff (!rstn) // [RQ11] [RQ12] [RQ13]
		rd_seen && hit(rd_addr, power_ctrl_pkg::OFS_BLOCK_IDENT) |-> hrdata == {24'h000000, 4'h4, MAKER_CONTINUATION})
		else $error("identification word wrong");
	a_lock_follow: assert property (@(posedge clk) disable iff (!rstn) // [RQ6] [RQ7] [RQ8]
		$past(rstn, 3) |-> pll_hi[15:8] == $past(cluster1_pll_locked, 2) && pll_lo[7] == $past(npu_pll_locked, 2))
		else $error("lock status not tracking inputs");
	a_lock_status_read: assert property (@(posedge clk) disable iff (!rstn) // [RQ6] [RQ8]
		take && !hwrite && hit(haddr[15:0], power_ctrl_pkg::OFS_PLL_LO) |=> hrdata == $past(pll_lo) && hrdata[2:1] == 2'h0)
		else $error("lock status read wrong");
	a_wakeup_follow: assert property (@(posedge clk) disable iff (!rstn) // [RQ14] [RQ1]
		$past(rstn) |-> wakeup_sleep_enabled_flag == $past(wakeup_sleep_request))
		else $error("wakeup status not following request");
	a_ready_okay: assert property (@(posedge clk) disable iff (!rstn) // [RQ15]
		hreadyout && !hresp)
		else $error("slave stalled or errored");

	// Remaining set patterns: each written one forces its clock,
	// a written zero leaves the other clock as it was
	a_set_ref_on: assert property (@(posedge clk) disable iff (!rstn) // [RQ4] [RQ3]
		set_write(2'h1) |=> ref_clock_force_bit && force_bus.state[0])
		else $error("reference clock not forced after set");
	a_set_both_on: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
		set_write(2'h3) |=> force_bus.state == 2'h3)
		else $error("both clocks not forced after set");
	a_set_zero_keep: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
		set_write(2'h0) |=> force_bus.state == $past(force_bus.state))
		else $error("zero set changed force state");

	// Remaining clear patterns: gating comes back only where a one is written
	a_clear_proc_off: assert property (@(posedge clk) disable iff (!rstn) // [RQ5] [RQ3]
		clear_write(2'h2) |=> !proc_clock_force_bit && !force_bus.state[1])
		else $error("processor clock still forced after clear");
	a_clear_both_off: assert property (@(posedge clk) disable iff (!rstn) // [RQ5]
		clear_write(2'h3) |=> force_bus.state == 2'h0)
		else $error("clocks still forced after full clear");

	// Writes to read-only or reserved words have no target, so the
	// force state must not move in their data phase
	a_other_write_keep: assert property (@(posedge clk) disable iff (!rstn) // [RQ15] [RQ16]
		wr_pending && !hit(wr_addr, power_ctrl_pkg::OFS_FORCE_SET) && !hit(wr_addr, power_ctrl_pkg::OFS_FORCE_CLEAR)
		|=> $stable(force_bus.state))
		else $error("force state moved on a foreign write");

	// Status read in the data phase matches the state that the same
	// address-phase edge loaded, forwarding included
	a_state_read: assert property (@(posedge clk) disable iff (!rstn) // [RQ2] [RQ3]
		rd_seen && hit(rd_addr, power_ctrl_pkg::OFS_FORCE_STATE) |-> hrdata == {30'h0, force_bus.state})
		else $error("force status read wrong");
	a_wakeup_read: assert property (@(posedge clk) disable iff (!rstn) // [RQ1] [RQ14]
		rd_seen && hit(rd_addr, power_ctrl_pkg::OFS_WAKEUP_STATE) |-> hrdata == {31'h0, $past(wakeup_sleep_enabled_flag)})
		else $error("wakeup status read wrong");
	a_lock_hi_read: assert property (@(posedge clk) disable iff (!rstn) // [RQ7] [RQ8]
		take && !hwrite && hit(haddr[15:0], power_ctrl_pkg::OFS_PLL_HI) |=> hrdata == $past(pll_hi) && hrdata[31:16] == 16'h0000)
		else $error("high lock status read wrong");

	// Lock images and wakeup flag start from zero after reset,
	// whatever the lock pins show while reset is released
	a_lock_reset: assert property (@(posedge clk) disable iff (!rstn) // [RQ8]
		!$past(rstn) |-> pll_lo == 32'h0000_0000 && pll_hi == 32'h0000_0000)
		else $error("lock status not zero after reset");
	a_wakeup_reset: assert property (@(posedge clk) disable iff (!rstn) // [RQ1]
		!$past(rstn) |-> !wakeup_sleep_enabled_flag)
		else $error("wakeup status not zero after reset");

	// Remaining lock lines, two cycles behind their pins; the delay is
	// the synchroniser and is the price of metastability safety
	a_lock_lo_map: assert property (@(posedge clk) disable iff (!rstn) // [RQ6] [RQ8]
		$past(rstn, 3) |-> pll_lo[6] == $past(display_pll_locked, 2)
		&& pll_lo[5] == $past(system_pll_locked, 2)
		&& pll_lo[4] == $past(video_pll_locked, 2))
		else $error("middle lock lines not tracking inputs");
	a_lock_rest_map: assert property (@(posedge clk) disable iff (!rstn) // [RQ6] [RQ7]
		$past(rstn, 3) |-> pll_lo[3] == $past(gpu_pll_locked, 2)
		&& pll_lo[0] == $past(ref_clock_state, 2)
		&& pll_hi[7:0] == $past(cluster0_pll_locked, 2))
		else $error("outer lock lines not tracking inputs");

endmodule

/* tb.sv */
// Self-checking bench for the clock force, lock status and identification register bank
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] TB_LOGIC_ID = 16'h1234; // Arbitrary value
	localparam logic [3:0] TB_MAKER = 4'h9; // Arbitrary value
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic wakeup_sleep_request = 1'b0;
	logic [5:0] lock_lo = 6'h0;
	logic [7:0] cl1 = 8'h0;
	logic [7:0] cl0 = 8'h0;
	logic proc_clock_force_bit;
	logic ref_clock_force_bit;
	logic wakeup_sleep_enabled_flag;
	int fails = 0;
	int checks = 0;
	logic [1:0] force_model;
	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	// Half period of 20 ns gives 25 MHz
	always #20 clk = ~clk;
	power_ctrl_clock_status_regs #(.LOGIC_ID(TB_LOGIC_ID), .MAKER_CONTINUATION(TB_MAKER)) i_power_ctrl_clock_status_regs (
		.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wakeup_sleep_request(wakeup_sleep_request), .npu_pll_locked(lock_lo[5]), .display_pll_locked(lock_lo[4]),
		.system_pll_locked(lock_lo[3]), .video_pll_locked(lock_lo[2]), .gpu_pll_locked(lock_lo[1]),
		.ref_clock_state(lock_lo[0]), .cluster1_pll_locked(cl1), .cluster0_pll_locked(cl0),
		.proc_clock_force_bit(proc_clock_force_bit), .ref_clock_force_bit(ref_clock_force_bit),
		.wakeup_sleep_enabled_flag(wakeup_sleep_enabled_flag)
	);
	// Verdict in one place, also reached by the watchdog
	task automatic summarize();
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask
	// Address phase held until ready, then data phase held until ready; entered just after an edge
	task automatic ahb_xfer(input logic [15:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {16'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		if (hresp !== 1'b0)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, hresp, 1'b0);
			fails++;
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb_xfer(a, 1'b1, d, q);
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb_xfer(a, 1'b0, 32'h0, q);
		check(q, exp);
	endtask
	// Expected lock words from the input pins
	function automatic logic [31:0] exp_lo(input logic [5:0] l);
		return {24'h0, l[5:1], 2'b00, l[0]};
	endfunction
	function automatic logic [31:0] exp_hi(input logic [7:0] c1, input logic [7:0] c0);
		return {16'h0, c1, c0};
	endfunction
	function automatic logic mapped(input logic [15:0] a);
		return a == 16'h0018 || a == 16'h0a00 || a == 16'h0a04 || a == 16'h0a08 || a == 16'h0a10 ||
			a == 16'h0a14 || a == 16'h0fc0 || a == 16'h0fd0 || a == 16'h0010 || a == 16'h0014 || a[15:12] == 4'h1;
	endfunction
	// Watchdog sized well above the roughly 1200 cycles the tests need
	initial
	begin
		#(40 * 30000);
		fails++;
		summarize();
	end
	initial
	begin
		logic [31:0] d;
		logic [15:0] a;
		void'($urandom(32'hc8c8d9b3));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		// Reset state of force bits and lock registers
		rd_chk(16'h0a00, 32'h0);
		rd_chk(16'h0a10, 32'h0);
		rd_chk(16'h0a14, 32'h0);
		// Fixed configuration and identification words, unchanged by writes
		for (int i = 0; i < 2; i++)
		begin
			rd_chk(16'h0fc0, {TB_LOGIC_ID, 12'h0, 4'h1});
			rd_chk(16'h0fd0, {24'h0, 4'h4, TB_MAKER});
			wr(16'h0fc0, $urandom());
			wr(16'h0fd0, $urandom());
		end
		// Random set and clear writes, back to back with status reads
		force_model = 2'h0;
		for (int i = 0; i < 60; i++)
		begin
			d = $urandom();
			if (i < 4)
				d = {30'h0, 2'(i)};
			if ($urandom() % 2)
			begin
				wr(16'h0a04, d);
				force_model = force_model | d[1:0];
			end
			else
			begin
				wr(16'h0a08, d);
				force_model = force_model & ~d[1:0];
			end
			rd_chk(16'h0a00, {30'h0, force_model});
			check({30'h0, proc_clock_force_bit, ref_clock_force_bit}, {30'h0, force_model});
			wr(16'h0a00, ~{30'h0, force_model});
			rd_chk(16'h0a04, 32'h0);
			rd_chk(16'h0a08, 32'h0);
			rd_chk(16'h0a00, {30'h0, force_model});
		end
		// Lock inputs: read after the synchroniser, writes have no effect
		for (int i = 0; i < 30; i++)
		begin
			lock_lo <= (i == 0) ? 6'h3f : 6'($urandom());
			cl1 <= (i == 0) ? 8'hff : 8'($urandom());
			cl0 <= 8'($urandom());
			wakeup_sleep_request <= 1'($urandom());
			repeat (3) @(posedge clk);
			wr(16'h0a10, $urandom());
			rd_chk(16'h0a10, exp_lo(lock_lo));
			rd_chk(16'h0a14, exp_hi(cl1, cl0));
			rd_chk(16'h0018, {31'h0, wakeup_sleep_request});
			check({31'h0, wakeup_sleep_enabled_flag}, {31'h0, wakeup_sleep_request});
		end
		// Reserved offsets read zero and ignore writes, including gaps beside mapped words
		for (int i = 0; i < 40; i++)
		begin
			a = {16'($urandom()) & 16'hfffc};
			if (i == 0)
				a = 16'h0a0c;
			if (i == 1)
				a = 16'h0fc4;
			if (!mapped(a))
			begin
				wr(a, 32'hffff_ffff);
				rd_chk(a, 32'h0);
			end
		end
		rd_chk(16'h0a00, {30'h0, force_model});
		summarize();
	end
endmodule
